// *** rtl/flash_ctrl_defs.vh ***
`ifndef FLASH_CTRL_DEFS_VH
`define FLASH_CTRL_DEFS_VH

// register indices
`define REG_CLKDIV      4'h0
`define REG_SECURITY    4'h1
`define REG_CONFIG      4'h2
`define REG_PROTECT     4'h3
`define REG_STATUS      4'h4
`define REG_COMMAND     4'h5
`define REG_ADDR_HI     4'h6
`define REG_ADDR_LO     4'h7
`define REG_DATA_HI     4'h8
`define REG_DATA_LO     4'h9
`define REG_MODE        4'ha

// command codes
`define CMD_ERASE_VERIFY 8'h05
`define CMD_PROGRAM      8'h20
`define CMD_SECTOR_ERASE 8'h40
`define CMD_MASS_ERASE   8'h41

// array addresses
`define SEC_BYTE_ADDR   16'hff0f
`define KEY_BASE_ADDR   16'hff00

// status bits
`define ST_COMMAND_BUFFER_EMPTY_FLAG        7
`define ST_COMMAND_COMPLETE_FLAG         6
`define ST_ACCESS_ERROR_FLAG       4
`define ST_BLANK        2

// clock divider fields
`define DIV_LOADED_BIT  7
`define DIV_PRESCALE_BIT 6

// config key access bit and security key-enable code
`define CFG_KEY_ACCESS_BIT_BIT  5
`define KEYEN_ENABLED   2'b10

// protection fields
`define PROT_OPEN_BIT   7
`define PROT_HDIS_BIT   5
`define PROT_LDIS_BIT   2

// security field: unsecured code in bits 1:0
`define SEC_UNSECURED   2'b10

// reset values
`define PROT_RESET      8'hff
`define CONFIG_RESET    8'h00

// timing counts in flash clock ticks, prescaler compare in clock cycles
`define PROG_TICKS      8'h08
`define SECTOR_TICKS    8'h40
`define MASS_TICKS      8'h80
`define VERIFY_TICKS    8'h10
`define PRESCALE_DIV    3'h7

`endif

// *** rtl/flash_command_security_ctrl.v ***
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - wait mode: finish active and queued commands
// - completion wakes waiting processor when enabled
// - stop aborts command, sets complete and error
// - stop exit: buffer empty, queued command dropped
// - protection register writable in debug mode
// - debug secured special mode: mass erase only
// - reset loads security byte from 0xff0f
// - secure stored byte restores secured state
// - key mode: key writes compare, not program
// - four key words in order unsecure
// - divider write once, loaded bit read-only
// - prescaler divides oscillator by eight
// - security register ignores bus writes
// - 0x05 verifies erased, sets blank bit
// - 0x20 programs one word
// - 0x40 erases a 1024-byte sector
// - 0x41 mass erase needs protect bits 7, 5 and 2 set
`include "flash_ctrl_defs.vh"

module flash_command_security_ctrl (
  // clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // system mode pins, asynchronous
  input wire wait_mode_i,
  input wire stop_mode_i,
  input wire debug_mode_i,
  input wire special_mode_i,
  // array side: stored configuration and key
  input wire [7:0] cfg_security_byte_i,
  input wire [63:0] cfg_backdoor_key_i,
  input wire array_blank_i,
  // array control
  output reg hv_enable_o,
  output reg [7:0] array_cmd_o,
  output reg [15:0] array_addr_o,
  output reg [15:0] array_data_o,
  output reg flash_tick_o,
  output reg wake_o,
  output reg unsecured_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_BUSY = 2'h1;
  localparam ST_LOAD = 2'h2;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [3:0] pin_meta_r; // first stage, read only by second
  reg [3:0] pin_sync_r; // {special, debug, stop, wait}
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {special_mode_i, debug_mode_i, stop_mode_i, wait_mode_i};
      pin_sync_r <= pin_meta_r;
    end
  end
  wire stop_s = pin_sync_r[1];
  wire debug_s = pin_sync_r[2];
  wire special_s = pin_sync_r[3];
  reg stop_d_r; // delayed stop for edge detection
  wire stop_exit = stop_d_r & ~stop_s;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [1:0] state_r;
  reg [7:0] clkdiv_r; // bit7 loaded, bit6 prescale, 5:0 divider
  reg [7:0] security_r; // loaded at reset only
  reg [7:0] config_r; // bit5 key access, bit0 interrupt enable
  reg [7:0] protect_r;
  reg command_buffer_empty_flag_r, command_complete_flag_r, access_error_flag_r, blank_r;
  reg [7:0] cmd_r; // launched command
  reg [15:0] addr_r, data_r; // staged address and data
  reg [7:0] q_cmd_r; // buffered command
  reg [15:0] q_addr_r, q_data_r;
  reg q_valid_r;
  reg [7:0] ticks_r; // remaining flash clock ticks
  reg [1:0] key_idx_r; // next expected key word
  reg key_ok_r; // all words so far matched
  reg [2:0] pre_cnt_r; // prescaler counter
  reg [5:0] div_cnt_r; // divider counter

  // key compare mode active
  wire key_mode = (security_r[7:6] == `KEYEN_ENABLED) & config_r[`CFG_KEY_ACCESS_BIT_BIT];
  wire secured = (security_r[1:0] != `SEC_UNSECURED) & ~unsecured_o;

  // decode used for writes; reads use a case on addr_i
  function sel;
    input [3:0] a;
    input [3:0] r;
    begin
      sel = (a == r);
    end
  endfunction

  // command acceptance: debug secured special allows mass erase only
  function cmd_allowed;
    input [7:0] c;
    input dbg, sec, spc;
    begin
      if (dbg & sec & spc)
        cmd_allowed = (c == `CMD_MASS_ERASE);
      else
        cmd_allowed = (c == `CMD_ERASE_VERIFY) | (c == `CMD_PROGRAM) |
                      (c == `CMD_SECTOR_ERASE) | (c == `CMD_MASS_ERASE);
    end
  endfunction

  // operation length for each command
  function [7:0] cmd_ticks;
    input [7:0] c;
    begin
      case (c)
        `CMD_PROGRAM: cmd_ticks = `PROG_TICKS;
        `CMD_SECTOR_ERASE: cmd_ticks = `SECTOR_TICKS;
        `CMD_MASS_ERASE: cmd_ticks = `MASS_TICKS;
        default: cmd_ticks = `VERIFY_TICKS;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // flash clock: optional divide by eight, then divider field
  // ----------------------------------------------------------------
  wire pre_tick = clkdiv_r[`DIV_PRESCALE_BIT] ? (pre_cnt_r == `PRESCALE_DIV) : 1'b1;
  wire div_tick = pre_tick & (div_cnt_r == clkdiv_r[5:0]);
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h0;
      flash_tick_o <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 3'h1;
      if (pre_tick)
        div_cnt_r <= div_tick ? 6'h0 : div_cnt_r + 6'h1;
      // no ticks until divider is loaded, as array timing would be wrong
      flash_tick_o <= div_tick & clkdiv_r[`DIV_LOADED_BIT];
    end
  end

  // ----------------------------------------------------------------
  // write side and command engine
  // ----------------------------------------------------------------
  wire wr_cmd = wr_i & sel(addr_i, `REG_COMMAND);
  // widen the staged address so both sides of the compare are 16 bits
  wire is_key_addr = ({3'h0, addr_r[15:3]} == (`KEY_BASE_ADDR >> 3));
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r <= ST_LOAD;
      clkdiv_r <= 8'h00;
      security_r <= 8'h00;
      config_r <= `CONFIG_RESET;
      protect_r <= `PROT_RESET;
      command_buffer_empty_flag_r <= 1'b1;
      command_complete_flag_r <= 1'b1;
      access_error_flag_r <= 1'b0;
      blank_r <= 1'b0;
      cmd_r <= 8'h00;
      addr_r <= 16'h0000;
      data_r <= 16'h0000;
      q_cmd_r <= 8'h00;
      q_addr_r <= 16'h0000;
      q_data_r <= 16'h0000;
      q_valid_r <= 1'b0;
      ticks_r <= 8'h00;
      key_idx_r <= 2'h0;
      key_ok_r <= 1'b1;
      unsecured_o <= 1'b0;
      hv_enable_o <= 1'b0;
      array_cmd_o <= 8'h00;
      array_addr_o <= 16'h0000;
      array_data_o <= 16'h0000;
      wake_o <= 1'b0;
      stop_d_r <= 1'b0;
    end else begin
      stop_d_r <= stop_s;
      wake_o <= command_complete_flag_r & config_r[0] & pin_sync_r[0];
      // bus writes
      if (wr_i) begin
        if (sel(addr_i, `REG_CLKDIV) & ~clkdiv_r[`DIV_LOADED_BIT])
          clkdiv_r <= {1'b1, wdata_i[6:0]};
        if (sel(addr_i, `REG_CONFIG))
          config_r <= wdata_i;
        if (sel(addr_i, `REG_PROTECT) & debug_s)
          protect_r <= wdata_i;
        if (sel(addr_i, `REG_ADDR_HI))
          addr_r[15:8] <= wdata_i;
        if (sel(addr_i, `REG_ADDR_LO))
          addr_r[7:0] <= wdata_i;
        if (sel(addr_i, `REG_DATA_HI))
          data_r[15:8] <= wdata_i;
        if (sel(addr_i, `REG_DATA_LO)) begin
          data_r[7:0] <= wdata_i;
          // key compare instead of a program
          if (key_mode & is_key_addr) begin
            if ({14'h0, key_idx_r} != {13'h0, addr_r[2:0]} >> 1 ||
                {data_r[15:8], wdata_i} != cfg_backdoor_key_i[63 - 16 * key_idx_r -: 16])
              key_ok_r <= 1'b0;
            key_idx_r <= key_idx_r + 2'h1;
            if (key_idx_r == 2'h3)
              unsecured_o <= key_ok_r & ({data_r[15:8], wdata_i} == cfg_backdoor_key_i[15:0])
                             & (addr_r[2:1] == 2'h3);
          end
        end
        // status: write one clears error set wins below
        if (sel(addr_i, `REG_STATUS) & wdata_i[`ST_ACCESS_ERROR_FLAG])
          access_error_flag_r <= 1'b0;
        // security register has no bus write path, only the reset load
      end
      // launching a command into the buffer
      if (wr_cmd) begin
        if (~command_buffer_empty_flag_r | access_error_flag_r | ~cmd_allowed(wdata_i, debug_s, secured, special_s) | stop_s)
          access_error_flag_r <= 1'b1;
        else begin
          q_cmd_r <= wdata_i;
          q_addr_r <= addr_r;
          q_data_r <= data_r;
          q_valid_r <= 1'b1;
          command_buffer_empty_flag_r <= 1'b0;
        end
      end
      case (state_r)
        ST_LOAD: begin
          // reset sequence copies stored security byte
          security_r <= cfg_security_byte_i;
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          // no launch on the stop exit cycle, the queued word is dropped there
          if (q_valid_r & ~stop_s & ~stop_exit) begin
            cmd_r <= q_cmd_r;
            array_cmd_o <= q_cmd_r;
            array_addr_o <= q_addr_r;
            array_data_o <= q_data_r;
            ticks_r <= cmd_ticks(q_cmd_r);
            q_valid_r <= 1'b0;
            command_buffer_empty_flag_r <= 1'b1;
            command_complete_flag_r <= 1'b0;
            blank_r <= 1'b0;
            // mass erase refused unless protection fully open
            if (q_cmd_r == `CMD_MASS_ERASE && !(protect_r[`PROT_LDIS_BIT] &
                protect_r[`PROT_HDIS_BIT] & protect_r[`PROT_OPEN_BIT])) begin
              access_error_flag_r <= 1'b1;
              command_complete_flag_r <= 1'b1;
            end else begin
              hv_enable_o <= (q_cmd_r != `CMD_ERASE_VERIFY);
              state_r <= ST_BUSY;
            end
          end
        end
        ST_BUSY: begin
          if (stop_s) begin
            // abort: data lost, high voltage off
            hv_enable_o <= 1'b0;
            command_complete_flag_r <= 1'b1;
            access_error_flag_r <= 1'b1;
            state_r <= ST_IDLE;
          end else if (flash_tick_o) begin
            // wait mode is ignored here so work runs to completion
            if (ticks_r == 8'h01) begin
              hv_enable_o <= 1'b0;
              if (q_valid_r)
                command_complete_flag_r <= 1'b0;
              else
                command_complete_flag_r <= 1'b1;
              if (cmd_r == `CMD_ERASE_VERIFY)
                blank_r <= array_blank_i;
              state_r <= ST_IDLE;
            end
            ticks_r <= ticks_r - 8'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      // leaving stop: buffer empties, queued work dropped
      if (stop_exit) begin
        q_valid_r <= 1'b0;
        command_buffer_empty_flag_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read side, data one cycle after strobe
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (rd_i) begin
      case (addr_i)
        `REG_CLKDIV: rdata_o <= clkdiv_r;
        `REG_SECURITY: rdata_o <= security_r;
        `REG_CONFIG: rdata_o <= config_r;
        `REG_PROTECT: rdata_o <= protect_r;
        `REG_STATUS: rdata_o <= {command_buffer_empty_flag_r, command_complete_flag_r, 1'b0, access_error_flag_r, 1'b0, blank_r, 2'b00};
        `REG_COMMAND: rdata_o <= cmd_r;
        `REG_ADDR_HI: rdata_o <= addr_r[15:8];
        `REG_ADDR_LO: rdata_o <= addr_r[7:0];
        `REG_DATA_HI: rdata_o <= data_r[15:8];
        `REG_DATA_LO: rdata_o <= data_r[7:0];
        `REG_MODE: rdata_o <= {4'h0, ~secured, special_s, debug_s, stop_s};
        default: rdata_o <= 8'h00;
      endcase
    end else
      rdata_o <= 8'h00;
  end

endmodule

// *** verification/flash_ctrl_chk.sv ***
`timescale 1ns/1ps
`include "flash_ctrl_defs.vh"
// ------------
// port checker
// ------------
module flash_ctrl_chk (
  // clock, reset, bus
  input wire clock_i,
  input wire rst_n_i,
  input wire [3:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // modes and array
  input wire wait_mode_i,
  input wire stop_mode_i,
  input wire [7:0] cfg_security_byte_i,
  input wire hv_enable_o,
  input wire [7:0] array_cmd_o,
  input wire [15:0] array_addr_o,
  input wire [15:0] array_data_o,
  input wire flash_tick_o,
  input wire wake_o
);
  reg div_w_r; // divider written since reset
  reg first_r; // first edge after reset release
  reg [7:0] sec_r; // byte the security register should hold
  // shadow what software and reset have done
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      div_w_r <= 1'b0;
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
      if (wr_i && addr_i == `REG_CLKDIV) div_w_r <= 1'b1;
      if (first_r) sec_r <= cfg_security_byte_i;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence div_rd_s;
    rd_i && addr_i == `REG_CLKDIV && div_w_r;
  endsequence
  sequence sec_rd_s;
    rd_i && addr_i == `REG_SECURITY;
  endsequence
  // margin of four covers the two-flop mode synchroniser
  stop_hv_off_a: assert property (stop_mode_i [*4] |=> !hv_enable_o)
    else $error("high voltage on in stop");
  stop_exit_a: assert property ($fell(stop_mode_i) |-> !hv_enable_o [*6])
    else $error("queued command ran after stop");
  wake_gate_a: assert property (!wait_mode_i [*4] |-> !wake_o)
    else $error("wake outside wait");
  tick_div_a: assert property (flash_tick_o |-> div_w_r)
    else $error("tick before divider set");
  div_loaded_a: assert property (div_rd_s |=> rdata_o[`DIV_LOADED_BIT])
    else $error("loaded bit clear");
  sec_read_a: assert property (sec_rd_s |=> rdata_o == sec_r)
    else $error("security read wrong");
  hv_cmd_a: assert property ($rose(hv_enable_o) |->
    array_cmd_o inside {`CMD_PROGRAM, `CMD_SECTOR_ERASE, `CMD_MASS_ERASE})
    else $error("high voltage for bad command");
  hv_hold_a: assert property (hv_enable_o [*2] |-> $stable(array_addr_o) && $stable(array_data_o))
    else $error("target moved during operation");
endmodule
bind flash_command_security_ctrl flash_ctrl_chk i_flash_ctrl_chk (.clock_i, .rst_n_i, .addr_i, .wr_i, .rd_i,
  .rdata_o, .wait_mode_i, .stop_mode_i, .cfg_security_byte_i, .hv_enable_o, .array_cmd_o, .array_addr_o,
  .array_data_o, .flash_tick_o, .wake_o);

// *** verification/flash_array_model.sv ***
`timescale 1ns/1ps
// --------------------
// flash array stand-in
// --------------------
module flash_array_model #(
  parameter [7:0] SEC_BYTE = 8'h80, // secured, key access enabled
  parameter [63:0] KEY = 64'h1234_5678_9abc_def0 // arbitrary key words
) (
  // controller side
  input wire clock_i,
  input wire hv_enable_i,
  input wire [7:0] array_cmd_i,
  output wire [7:0] sec_byte_o,
  output wire [63:0] key_o,
  output reg blank_o
);
  reg hv_r = 1'b0; // last cycle's high voltage
  initial blank_o = 1'b0;
  assign sec_byte_o = SEC_BYTE;
  assign key_o = KEY;
  // blank only when high voltage drops on a mass erase, finished or aborted; a program dirties it
  always @(posedge clock_i) begin
    hv_r <= hv_enable_i;
    if (hv_r && !hv_enable_i) blank_o <= (array_cmd_i == 8'h41);
  end
endmodule

// *** verification/flash_command_security_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "flash_ctrl_defs.vh"
// ---------------
// controller bench
// ---------------
module flash_command_security_ctrl_tb;
  reg clock_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg wait_mode_i = 1'b0;
  reg stop_mode_i = 1'b0;
  reg debug_mode_i = 1'b0;
  reg special_mode_i = 1'b0;
  wire [7:0] rdata_o, array_cmd_o, sec_byte;
  wire [15:0] array_addr_o, array_data_o;
  wire [63:0] key;
  wire blank, hv_enable_o, flash_tick_o, wake_o, unsecured_o;
  integer err_total = 0;
  integer samples_checked = 0;
  integer i, j;
  reg [7:0] rd_r; // last read data
  flash_command_security_ctrl i_flash_command_security_ctrl (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .wait_mode_i, .stop_mode_i, .debug_mode_i, .special_mode_i, .cfg_security_byte_i(sec_byte),
    .cfg_backdoor_key_i(key), .array_blank_i(blank), .hv_enable_o, .array_cmd_o, .array_addr_o,
    .array_data_o, .flash_tick_o, .wake_o, .unsecured_o);
  flash_array_model i_flash_array_model (.clock_i, .hv_enable_i(hv_enable_o), .array_cmd_i(array_cmd_o),
    .sec_byte_o(sec_byte), .key_o(key), .blank_o(blank));
  initial forever #20 clock_i = ~clock_i;
  task chk(input string what, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [3:0] a);
    begin
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 rd_r = rdata_o;
    end
  endtask
  // a zero command code only loads address and data
  task launch(input [15:0] a, input [15:0] d, input [7:0] c);
    begin
      wr(`REG_ADDR_HI, a[15:8]);
      wr(`REG_ADDR_LO, a[7:0]);
      wr(`REG_DATA_HI, d[15:8]);
      wr(`REG_DATA_LO, d[7:0]);
      if (c != 8'h00) wr(`REG_COMMAND, c);
    end
  endtask
  // bounded wait on the complete flag; giving up ends the run
  task poll;
    begin
      for (i = 0; i < 3000; i = i + 1) begin
        rd(`REG_STATUS);
        if (rd_r[`ST_COMMAND_COMPLETE_FLAG] === 1'b1) i = 9999;
      end
      if (i == 3000) begin
        chk("poll", 0, 1);
        final_report;
      end
    end
  endtask
  task settle;
    begin
      repeat (4) @(posedge clock_i);
      #1;
    end
  endtask
  task t_regs;
    begin
      rd(`REG_SECURITY);
      chk("security", rd_r, 8'h80);
      wr(`REG_SECURITY, 8'h02);
      rd(`REG_SECURITY);
      chk("security ro", rd_r, 8'h80);
      wr(`REG_CLKDIV, 8'h41);
      wr(`REG_CLKDIV, 8'h03);
      rd(`REG_CLKDIV);
      chk("clkdiv", rd_r, 8'hc1);
      $display("regs done");
    end
  endtask
  task t_prog;
    begin
      wr(`REG_CONFIG, 8'h01);
      launch(16'h1234, 16'hbeef, `CMD_PROGRAM);
      wait_mode_i <= 1'b1;
      rd(`REG_STATUS);
      chk("busy", rd_r[`ST_COMMAND_COMPLETE_FLAG], 1'b0);
      chk("addr", array_addr_o, 16'h1234);
      chk("data", array_data_o, 16'hbeef);
      poll;
      settle;
      chk("wake", wake_o, 1'b1);
      wait_mode_i <= 1'b0;
      $display("prog done");
    end
  endtask
  task t_erase;
    begin
      launch(16'h0000, 16'h0000, `CMD_ERASE_VERIFY);
      poll;
      chk("dirty", rd_r[`ST_BLANK], 1'b0);
      debug_mode_i <= 1'b1;
      special_mode_i <= 1'b1;
      settle;
      wr(`REG_PROTECT, 8'h00);
      rd(`REG_PROTECT);
      chk("protect dbg", rd_r, 8'h00);
      for (j = 0; j < 2; j = j + 1) begin
        launch(16'h0000, 16'h0000, j ? `CMD_MASS_ERASE : `CMD_PROGRAM);
        rd(`REG_STATUS);
        chk("refused", rd_r[`ST_ACCESS_ERROR_FLAG], 1'b1);
        wr(`REG_STATUS, 8'h10);
      end
      wr(`REG_PROTECT, 8'hff);
      launch(16'h0000, 16'h0000, `CMD_MASS_ERASE);
      poll;
      chk("mass", rd_r[`ST_ACCESS_ERROR_FLAG], 1'b0);
      debug_mode_i <= 1'b0;
      special_mode_i <= 1'b0;
      settle;
      launch(16'h0000, 16'h0000, `CMD_ERASE_VERIFY);
      poll;
      chk("blank", rd_r[`ST_BLANK], 1'b1);
      $display("erase done");
    end
  endtask
  task t_stop;
    begin
      launch(16'h0400, 16'h0000, `CMD_SECTOR_ERASE);
      launch(16'h0800, 16'h0000, `CMD_SECTOR_ERASE);
      stop_mode_i <= 1'b1;
      settle;
      rd(`REG_STATUS);
      chk("abort", rd_r & 8'h50, 8'h50);
      stop_mode_i <= 1'b0;
      settle;
      rd(`REG_STATUS);
      chk("exit", rd_r[`ST_COMMAND_BUFFER_EMPTY_FLAG], 1'b1);
      chk("dropped", hv_enable_o, 1'b0);
      wr(`REG_STATUS, 8'h10);
      $display("stop done");
    end
  endtask
  // key words compare instead of programming
  task t_key;
    begin
      wr(`REG_CONFIG, 8'h20);
      for (j = 0; j < 4; j = j + 1)
        launch({8'hff, 5'h00, j[1:0], 1'b0}, key[63 - 16 * j -: 16], 8'h00);
      settle;
      chk("no prog", hv_enable_o, 1'b0);
      chk("unsecured", unsecured_o, 1'b1);
      $display("key done");
    end
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_regs;
    t_prog;
    t_erase;
    t_stop;
    t_key;
    final_report;
  end
endmodule
